// file: hdl/ievs_top.sv
// Interrupt event capture for codec link, serial ports, peripheral bus and pins
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module ievs_top
  import ievs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [31:0] RDATA,
  output logic LOW_PRIORITY_REQUEST,
  input wire logic TELECOM_DMA_END,
  input wire logic SOUND_DMA_STEP,
  input wire logic TELECOM_DMA_STEP,
  input wire logic SF1_LEFT_CLIP,
  input wire logic SF1_RIGHT_CLIP,
  input wire logic SF0_SOUND_VALID,
  input wire logic SF1_SOUND_VALID,
  input wire logic SF0_TELECOM_VALID,
  input wire logic SF1_TELECOM_VALID,
  input wire logic SOUND_RX_LOADED,
  input wire logic TELECOM_RX_LOADED,
  input wire logic SUBFRAME0_START,
  input wire logic SUBFRAME1_START,
  input wire logic CODEC_LINK_IRQ_PIN,
  input wire logic [1:0] PORT_RX_LOAD,
  input wire logic [1:0] PORT_FRAME_ERR,
  input wire logic [1:0] PORT_BREAK,
  input wire logic [1:0] PORT_PARITY_ERR,
  input wire logic [1:0] PORT_TX_AVAIL,
  input wire logic [1:0] PORT_TX_WRITE,
  input wire logic [1:0] PORT_EMPTY,
  input wire logic [1:0] PORT_DMA_END,
  input wire logic [1:0] PORT_DMA_MID,
  input wire logic PBUS_TX_MOVE,
  input wire logic PBUS_TX_WRITE_UNAVAIL,
  input wire logic PBUS_EMPTY,
  input wire logic PBUS_RX_LOAD,
  input wire logic PBUS_CMD_DETECT,
  input wire logic PBUS_DMA_END,
  input wire logic PBUS_DMA_MID,
  input wire logic PBUS_IRQ_SIGNAL,
  input wire logic [31:0] MULTIFUNC_PIN
);
  ievs_state_s st_reg;
  ievs_state_s st_next;
  logic [31:0] set1;
  logic [31:0] set2;
  logic [31:0] set3;
  logic [31:0] clr1;
  logic [31:0] clr2;
  logic [31:0] clr3;
  logic snd_valid;
  logic tel_valid;

  // Stage two and three agree before a pin change counts
  function automatic logic [33:0] ievs_agree(input logic [33:0] a, input logic [33:0] b,
                                              input logic [33:0] old);
    ievs_agree = (a & b) | (old & (a | b));
  endfunction : ievs_agree

  function automatic logic [31:0] ievs_sticky(input logic [31:0] cur, input logic [31:0] set,
                                               input logic [31:0] clr);
    ievs_sticky = set | (cur & ~clr);
  endfunction : ievs_sticky

  always_comb begin
    logic [33:0] filt;
    logic [33:0] prev;
    filt = '0;
    prev = '0;
    st_next = st_reg;
    // Edges are taken against the agreed level, never against a raw stage
    prev = st_reg.filt_reg;
    st_next.s0_reg = {CODEC_LINK_IRQ_PIN, PBUS_IRQ_SIGNAL, MULTIFUNC_PIN};
    st_next.s1_reg = st_reg.s0_reg;
    filt = ievs_agree(st_reg.s1_reg, st_reg.s2_reg, prev);
    st_next.s2_reg = st_reg.s1_reg;
    // Sound and telecom valid flags follow the selected subframe
    snd_valid = st_reg.ctrl_reg[IEVS_CTRL_SNDSEL_BIT] ? SF1_SOUND_VALID : SF0_SOUND_VALID;
    tel_valid = st_reg.ctrl_reg[IEVS_CTRL_TELSEL_BIT] ? SF1_TELECOM_VALID
                                                      : SF0_TELECOM_VALID;
    set1 = '0;
    set1[IEVS_S1_TEL_END] = TELECOM_DMA_END;
    set1[IEVS_S1_SND_STEP] = SOUND_DMA_STEP;
    set1[IEVS_S1_TEL_STEP] = TELECOM_DMA_STEP;
    set1[IEVS_S1_LCLIP] = SF1_LEFT_CLIP;
    set1[IEVS_S1_RCLIP] = SF1_RIGHT_CLIP;
    set1[IEVS_S1_SND_RISE] = snd_valid & ~st_reg.snd_valid_reg;
    set1[IEVS_S1_SND_FALL] = ~snd_valid & st_reg.snd_valid_reg;
    set1[IEVS_S1_TEL_RISE] = tel_valid & ~st_reg.tel_valid_reg;
    set1[IEVS_S1_TEL_FALL] = ~tel_valid & st_reg.tel_valid_reg;
    set1[IEVS_S1_SND_IN] = SOUND_RX_LOADED;
    set1[IEVS_S1_TEL_IN] = TELECOM_RX_LOADED;
    set1[IEVS_S1_SF0] = SUBFRAME0_START;
    set1[IEVS_S1_SF1] = SUBFRAME1_START;
    set1[IEVS_S1_IRQ_RISE] = filt[33] & ~prev[33];
    set1[IEVS_S1_IRQ_FALL] = ~filt[33] & prev[33];
    set2 = '0;
    for (int p = 0; p < 2; p++) begin
      int b;
      b = (p == 0) ? IEVS_S2_PA_BASE : IEVS_S2_PB_BASE;
      set2[b + 9] = PORT_RX_LOAD[p];
      // Overrun: a load while the previous one is still unserviced
      set2[b + 8] = PORT_RX_LOAD[p] & st_reg.rx_pend_reg[p];
      set2[b + 7] = PORT_RX_LOAD[p] & PORT_FRAME_ERR[p];
      set2[b + 6] = PORT_RX_LOAD[p] & PORT_BREAK[p];
      set2[b + 5] = PORT_RX_LOAD[p] & PORT_PARITY_ERR[p];
      set2[b + 4] = PORT_TX_AVAIL[p];
      set2[b + 3] = PORT_TX_WRITE[p] & ~PORT_TX_AVAIL[p];
      set2[b + 2] = PORT_EMPTY[p];
      set2[b + 1] = PORT_DMA_END[p];
      set2[b] = PORT_DMA_MID[p];
    end
    set2[IEVS_S2_PB_TXAV] = PBUS_TX_MOVE |
      (st_reg.ctrl_reg[IEVS_CTRL_PBUSEN_BIT] & ~st_reg.pbus_en_old_reg);
    set2[IEVS_S2_PB_TXERR] = PBUS_TX_WRITE_UNAVAIL;
    set2[IEVS_S2_PB_EMPTY] = PBUS_EMPTY;
    set2[IEVS_S2_PB_RXAV] = PBUS_RX_LOAD;
    set2[IEVS_S2_PB_RXERR] = PBUS_RX_LOAD & st_reg.pbus_rx_pend_reg;
    set2[IEVS_S2_PB_DET] = PBUS_CMD_DETECT;
    set2[IEVS_S2_PB_END] = PBUS_DMA_END;
    set2[IEVS_S2_PB_MID] = PBUS_DMA_MID;
    set2[IEVS_S2_PB_RISE] = filt[32] & ~prev[32];
    set2[IEVS_S2_PB_FALL] = ~filt[32] & prev[32];
    set3 = filt[31:0] & ~prev[31:0];
    // Agreed level is kept apart from the raw third stage
    st_next.filt_reg = filt;
    clr1 = (WR_STB && ADDR == IEVS_STAT1_OFS) ? WDATA : '0;
    clr2 = (WR_STB && ADDR == IEVS_STAT2_OFS) ? WDATA : '0;
    clr3 = (WR_STB && ADDR == IEVS_STAT3_OFS) ? WDATA : '0;
    // Reserved low bits of status 1 and 2 never set
    st_next.stat1_reg = ievs_sticky(st_reg.stat1_reg, set1, clr1) & 32'h000f_ffe0;
    st_next.stat2_reg = ievs_sticky(st_reg.stat2_reg, set2, clr2) & 32'hffff_fffc;
    st_next.stat3_reg = ievs_sticky(st_reg.stat3_reg, set3, clr3);
    st_next.snd_valid_reg = snd_valid;
    st_next.tel_valid_reg = tel_valid;
    st_next.pbus_irq_reg = filt[32];
    st_next.pbus_en_old_reg = st_reg.ctrl_reg[IEVS_CTRL_PBUSEN_BIT];
    // Pending tracks the receive flag: serviced once software clears it
    for (int p = 0; p < 2; p++) begin
      int b;
      b = (p == 0) ? IEVS_S2_PA_BASE : IEVS_S2_PB_BASE;
      st_next.rx_pend_reg[p] = st_next.stat2_reg[b + 9];
    end
    st_next.pbus_rx_pend_reg = st_next.stat2_reg[IEVS_S2_PB_RXAV];
    if (WR_STB) begin
      case (ADDR)
        IEVS_EN1_OFS: st_next.en1_reg = WDATA;
        IEVS_EN2_OFS: st_next.en2_reg = WDATA;
        IEVS_EN3_OFS: st_next.en3_reg = WDATA;
        IEVS_CTRL_OFS: st_next.ctrl_reg = WDATA[3:0];
        default: st_next.ctrl_reg = st_reg.ctrl_reg;
      endcase
    end
    st_next.rdata_reg = '0;
    if (RD_STB) begin
      case (ADDR)
        IEVS_STAT1_OFS: st_next.rdata_reg = st_reg.stat1_reg;
        IEVS_STAT2_OFS: st_next.rdata_reg = st_reg.stat2_reg;
        IEVS_STAT3_OFS: st_next.rdata_reg = st_reg.stat3_reg;
        IEVS_EN1_OFS: st_next.rdata_reg = st_reg.en1_reg;
        IEVS_EN2_OFS: st_next.rdata_reg = st_reg.en2_reg;
        IEVS_EN3_OFS: st_next.rdata_reg = st_reg.en3_reg;
        IEVS_CTRL_OFS: st_next.rdata_reg = {28'h0000000, st_reg.ctrl_reg};
        default: st_next.rdata_reg = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA = st_reg.rdata_reg;
  assign LOW_PRIORITY_REQUEST = st_reg.ctrl_reg[IEVS_CTRL_GLOBAL_BIT] &
    (|(st_reg.stat1_reg & st_reg.en1_reg) | |(st_reg.stat2_reg & st_reg.en2_reg) |
     |(st_reg.stat3_reg & st_reg.en3_reg));

  // Pin-rise bit must follow an agreed rising edge two cycles on
  pin_rise_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.s0_reg[0] && st_reg.s1_reg[0] && !st_reg.s2_reg[0] && !st_reg.filt_reg[0]
    |-> ##2 st_reg.stat3_reg[0])
    else $error("pin rise not captured");

  pin_top_rise_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.s1_reg[31] && st_reg.s2_reg[31] && !st_reg.filt_reg[31]
    |=> st_reg.stat3_reg[31])
    else $error("top pin rise not captured");

  codec_rise_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.s1_reg[33] && st_reg.s2_reg[33] && !st_reg.filt_reg[33]
    |=> st_reg.stat1_reg[IEVS_S1_IRQ_RISE])
    else $error("codec request rise missed");

  codec_fall_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !st_reg.s1_reg[33] && !st_reg.s2_reg[33] && st_reg.filt_reg[33]
    |=> st_reg.stat1_reg[IEVS_S1_IRQ_FALL])
    else $error("codec request fall missed");

  pbus_rise_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.s1_reg[32] && st_reg.s2_reg[32] && !st_reg.filt_reg[32]
    |=> st_reg.stat2_reg[IEVS_S2_PB_RISE])
    else $error("bus request rise missed");

  pbus_fall_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !st_reg.s1_reg[32] && !st_reg.s2_reg[32] && st_reg.filt_reg[32]
    |=> st_reg.stat2_reg[IEVS_S2_PB_FALL])
    else $error("bus request fall missed");

  snd_step_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SOUND_DMA_STEP |=> st_reg.stat1_reg[IEVS_S1_SND_STEP])
    else $error("sound step lost");

  tel_step_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    TELECOM_DMA_STEP |=> st_reg.stat1_reg[IEVS_S1_TEL_STEP])
    else $error("telecom step lost");

  left_clip_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SF1_LEFT_CLIP |=> st_reg.stat1_reg[IEVS_S1_LCLIP])
    else $error("left clip lost");

  right_clip_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SF1_RIGHT_CLIP |=> st_reg.stat1_reg[IEVS_S1_RCLIP])
    else $error("right clip lost");

  snd_fall_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !st_reg.ctrl_reg[IEVS_CTRL_SNDSEL_BIT] && $fell(SF0_SOUND_VALID) && !$changed(st_reg.ctrl_reg)
    |=> st_reg.stat1_reg[IEVS_S1_SND_FALL])
    else $error("sound valid fall missed");

  snd_select_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.ctrl_reg[IEVS_CTRL_SNDSEL_BIT] && $rose(SF1_SOUND_VALID) && !$changed(st_reg.ctrl_reg)
    |=> st_reg.stat1_reg[IEVS_S1_SND_RISE])
    else $error("selected sound valid rise missed");

  tel_select_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.ctrl_reg[IEVS_CTRL_TELSEL_BIT] && $rose(SF1_TELECOM_VALID)
    && !$changed(st_reg.ctrl_reg) |=> st_reg.stat1_reg[IEVS_S1_TEL_RISE])
    else $error("selected telecom valid rise missed");

  snd_in_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SOUND_RX_LOADED |=> st_reg.stat1_reg[IEVS_S1_SND_IN])
    else $error("sound input lost");

  tel_in_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    TELECOM_RX_LOADED |=> st_reg.stat1_reg[IEVS_S1_TEL_IN])
    else $error("telecom input lost");

  sf0_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SUBFRAME0_START |=> st_reg.stat1_reg[IEVS_S1_SF0])
    else $error("subframe 0 start lost");

  sf1_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SUBFRAME1_START |=> st_reg.stat1_reg[IEVS_S1_SF1])
    else $error("subframe 1 start lost");

  port_b_overrun_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_RX_LOAD[1] && st_reg.stat2_reg[IEVS_S2_PB_BASE + 9]
    |=> st_reg.stat2_reg[IEVS_S2_PB_BASE + 8])
    else $error("port b overrun missed");

  frame_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_RX_LOAD[0] && PORT_FRAME_ERR[0] |=> st_reg.stat2_reg[IEVS_S2_PA_BASE + 7])
    else $error("frame error lost");

  tx_overrun_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_TX_WRITE[1] && !PORT_TX_AVAIL[1] |=> st_reg.stat2_reg[IEVS_S2_PB_BASE + 3])
    else $error("transmit overrun lost");

  port_empty_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_EMPTY[1] |=> st_reg.stat2_reg[IEVS_S2_PB_BASE + 2])
    else $error("port empty lost");

  dma_mid_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_DMA_MID[0] |=> st_reg.stat2_reg[IEVS_S2_PA_BASE])
    else $error("port dma midpoint lost");

  dma_end_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_DMA_END[1] |=> st_reg.stat2_reg[IEVS_S2_PB_BASE + 1])
    else $error("port dma end lost");

  pbus_move_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_TX_MOVE |=> st_reg.stat2_reg[IEVS_S2_PB_TXAV])
    else $error("bus transfer did not flag available");

  pbus_double_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_RX_LOAD && st_reg.stat2_reg[IEVS_S2_PB_RXAV] |=> st_reg.stat2_reg[IEVS_S2_PB_RXERR])
    else $error("bus double load missed");

  pbus_txerr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_TX_WRITE_UNAVAIL |=> st_reg.stat2_reg[IEVS_S2_PB_TXERR])
    else $error("bus transmit error lost");

  pbus_empty_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_EMPTY |=> st_reg.stat2_reg[IEVS_S2_PB_EMPTY])
    else $error("bus empty lost");

  pbus_detect_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_CMD_DETECT |=> st_reg.stat2_reg[IEVS_S2_PB_DET])
    else $error("bus detect lost");

  pbus_dma_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PBUS_DMA_END |=> st_reg.stat2_reg[IEVS_S2_PB_END])
    else $error("bus dma end lost");

  low_req_on_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.ctrl_reg[IEVS_CTRL_GLOBAL_BIT] && |(st_reg.stat3_reg & st_reg.en3_reg)
    |-> LOW_PRIORITY_REQUEST)
    else $error("enabled status gave no request");

  // No disable here: this one must look while reset is held
  reset_clear_a: assert property (@(posedge CLK_SYS)
    !RST_B |-> st_reg.stat1_reg == 32'h0000_0000 && !st_reg.ctrl_reg[IEVS_CTRL_GLOBAL_BIT])
    else $error("reset left state behind");

  sticky_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_reg.stat2_reg[IEVS_S2_PB_DET] && !(WR_STB && ADDR == IEVS_STAT2_OFS)
    |=> st_reg.stat2_reg[IEVS_S2_PB_DET])
    else $error("status bit dropped without clear");
  set_wins_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    TELECOM_DMA_END |=> st_reg.stat1_reg[IEVS_S1_TEL_END])
    else $error("set lost");
  clear_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    WR_STB && ADDR == IEVS_STAT2_OFS && WDATA[IEVS_S2_PB_DET] && !PBUS_CMD_DETECT
    |=> !st_reg.stat2_reg[IEVS_S2_PB_DET])
    else $error("clear ignored");
  low_req_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    LOW_PRIORITY_REQUEST |-> st_reg.ctrl_reg[IEVS_CTRL_GLOBAL_BIT])
    else $error("request without global enable");
  rx_overrun_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PORT_RX_LOAD[0] && st_reg.stat2_reg[IEVS_S2_PA_BASE + 9]
    |=> st_reg.stat2_reg[IEVS_S2_PA_BASE + 8])
    else $error("overrun missed");
  snd_rise_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !st_reg.ctrl_reg[IEVS_CTRL_SNDSEL_BIT] && $rose(SF0_SOUND_VALID) && !$changed(st_reg.ctrl_reg)
    |=> st_reg.stat1_reg[IEVS_S1_SND_RISE])
    else $error("sound valid rise missed");
  pbus_enable_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(st_reg.ctrl_reg[IEVS_CTRL_PBUSEN_BIT]) |=> st_reg.stat2_reg[IEVS_S2_PB_TXAV])
    else $error("enable did not flag transmit available");
endmodule : ievs_top

// file: shared/ievs_pkg.sv
// Constants and types for the interrupt event status block
package ievs_pkg;
  localparam logic [11:0] IEVS_STAT1_OFS = 12'h100;
  localparam logic [11:0] IEVS_STAT2_OFS = 12'h104;
  localparam logic [11:0] IEVS_STAT3_OFS = 12'h108;
  localparam logic [11:0] IEVS_EN1_OFS = 12'h120;
  localparam logic [11:0] IEVS_EN2_OFS = 12'h124;
  localparam logic [11:0] IEVS_EN3_OFS = 12'h128;
  localparam logic [11:0] IEVS_CTRL_OFS = 12'h130;
  localparam int IEVS_CTRL_GLOBAL_BIT = 0;
  localparam int IEVS_CTRL_SNDSEL_BIT = 1;
  localparam int IEVS_CTRL_TELSEL_BIT = 2;
  localparam int IEVS_CTRL_PBUSEN_BIT = 3;
  localparam logic [31:0] IEVS_ZERO_RST = 32'h0000_0000;
  // Status 1 bit positions
  localparam int IEVS_S1_TEL_END = 19;
  localparam int IEVS_S1_SND_STEP = 18;
  localparam int IEVS_S1_TEL_STEP = 17;
  localparam int IEVS_S1_LCLIP = 16;
  localparam int IEVS_S1_RCLIP = 15;
  localparam int IEVS_S1_SND_RISE = 14;
  localparam int IEVS_S1_SND_FALL = 13;
  localparam int IEVS_S1_TEL_RISE = 12;
  localparam int IEVS_S1_TEL_FALL = 11;
  localparam int IEVS_S1_SND_IN = 10;
  localparam int IEVS_S1_TEL_IN = 9;
  localparam int IEVS_S1_SF0 = 8;
  localparam int IEVS_S1_SF1 = 7;
  localparam int IEVS_S1_IRQ_RISE = 6;
  localparam int IEVS_S1_IRQ_FALL = 5;
  // Status 2: port A base 22, port B base 12, ten bits each from rx (high) down
  localparam int IEVS_S2_PA_BASE = 22;
  localparam int IEVS_S2_PB_BASE = 12;
  localparam int IEVS_S2_PB_TXAV = 11;
  localparam int IEVS_S2_PB_TXERR = 10;
  localparam int IEVS_S2_PB_EMPTY = 9;
  localparam int IEVS_S2_PB_RXAV = 8;
  localparam int IEVS_S2_PB_RXERR = 7;
  localparam int IEVS_S2_PB_DET = 6;
  localparam int IEVS_S2_PB_END = 5;
  localparam int IEVS_S2_PB_MID = 4;
  localparam int IEVS_S2_PB_RISE = 3;
  localparam int IEVS_S2_PB_FALL = 2;
  localparam int IEVS_SYNC_STAGES = 3;
  typedef struct packed {
    logic [31:0] stat1_reg;
    logic [31:0] stat2_reg;
    logic [31:0] stat3_reg;
    logic [31:0] en1_reg;
    logic [31:0] en2_reg;
    logic [31:0] en3_reg;
    logic [3:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic [33:0] s0_reg;
    logic [33:0] s1_reg;
    logic [33:0] s2_reg;
    logic [33:0] filt_reg;
    logic snd_valid_reg;
    logic tel_valid_reg;
    logic pbus_irq_reg;
    logic [1:0] rx_pend_reg;
    logic pbus_rx_pend_reg;
    logic pbus_en_old_reg;
  } ievs_state_s;
endpackage : ievs_pkg

// file: test/ievs_cpu_model.sv
// Bus master model of the CPU core that reads and clears event status
`timescale 1ns/10ps
module ievs_cpu_model (
  input wire logic CLK_SYS,
  input wire logic [31:0] RDATA,
  output logic [11:0] ADDR,
  output logic [31:0] WDATA,
  output logic WR_STB,
  output logic RD_STB
);
  initial begin
    ADDR = 12'h000;
    WDATA = 32'h0000_0000;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
  end
  // Ones written to a status offset clear those bits only
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
    // Released bus shows the inverse so stale values cannot pass
    ADDR <= ~a;
    WDATA <= ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    ADDR <= ~a;
    // Read data stand for this one cycle; take them mid-cycle, clear of the edges
    @(negedge CLK_SYS);
    d = RDATA;
  endtask : rd
endmodule : ievs_cpu_model

// file: test/ievs_tb_top.sv
// Self-checking testbench for the interrupt event status block
`timescale 1ns/10ps
module ievs_tb_top;
  import ievs_pkg::*;
  localparam int PB[22] = '{19, 18, 17, 16, 15, 10, 9, 8, 7, 26, 16, 24, 14, 23, 13, 22, 12,
    11, 9, 6, 5, 4};
  logic clk, rst_b, cpin, pirq, prxl, ptxe;
  logic [21:0] pl;
  logic [3:0] vl;
  logic [31:0] mpin, m;
  logic [1:0] rxl, fe, brk, par, txw;
  logic [11:0] ad;
  logic [2:0] e;
  wire [11:0] addr;
  wire [31:0] wdata, rdata;
  wire wr, rd, lpr;
  int failures, total_checks, cycles;
  ievs_cpu_model cpu (.CLK_SYS(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr), .RD_STB(rd));
  ievs_top DUT (.CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr),
    .RD_STB(rd), .RDATA(rdata), .LOW_PRIORITY_REQUEST(lpr), .TELECOM_DMA_END(pl[0]),
    .SOUND_DMA_STEP(pl[1]), .TELECOM_DMA_STEP(pl[2]), .SF1_LEFT_CLIP(pl[3]),
    .SF1_RIGHT_CLIP(pl[4]), .SF0_SOUND_VALID(vl[0]), .SF1_SOUND_VALID(vl[2]),
    .SF0_TELECOM_VALID(vl[1]), .SF1_TELECOM_VALID(vl[3]), .SOUND_RX_LOADED(pl[5]),
    .TELECOM_RX_LOADED(pl[6]), .SUBFRAME0_START(pl[7]), .SUBFRAME1_START(pl[8]),
    .CODEC_LINK_IRQ_PIN(cpin), .PORT_RX_LOAD(rxl), .PORT_FRAME_ERR(fe), .PORT_BREAK(brk),
    .PORT_PARITY_ERR(par), .PORT_TX_AVAIL(pl[10:9]), .PORT_TX_WRITE(txw),
    .PORT_EMPTY(pl[12:11]), .PORT_DMA_END(pl[14:13]), .PORT_DMA_MID(pl[16:15]),
    .PBUS_TX_MOVE(pl[17]), .PBUS_TX_WRITE_UNAVAIL(ptxe), .PBUS_EMPTY(pl[18]),
    .PBUS_RX_LOAD(prxl), .PBUS_CMD_DETECT(pl[19]), .PBUS_DMA_END(pl[20]),
    .PBUS_DMA_MID(pl[21]), .PBUS_IRQ_SIGNAL(pirq), .MULTIFUNC_PIN(mpin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] v;
    cpu.rd(a, v);
    chk(n, x, v);
  endtask : rchk
  // Serial port status word after loads: rx, overrun, errors, tx overrun
  function automatic logic [31:0] rx_exp(int p, logic [2:0] q, logic o);
    return 32'({1'b1, o, q, 1'b0, o}) << ((p == 1 ? 12 : 22) + 3);
  endfunction : rx_exp
  task automatic load_rx(input int p, input logic [2:0] q);
    @(posedge clk);
    rxl <= 2'(1) << p;
    fe <= 2'(q[2]) << p;
    brk <= 2'(q[1]) << p;
    par <= 2'(q[0]) << p;
    @(posedge clk);
    {rxl, fe, brk, par} <= '0;
  endtask : load_rx
  task automatic pulse(input int i);
    @(posedge clk) pl <= 22'(1) << i;
    @(posedge clk) pl <= '0;
  endtask : pulse
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {pl, vl, cpin, pirq, mpin, rxl, fe, brk, par, txw, prxl, ptxe} = '0;
    {failures, total_checks, cycles} = '0;
    rst_b = 1'b0;
    void'($urandom(26668));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 3; a++) rchk("reset status", 12'h100 + 12'(4 * a), 32'h0);
    for (int i = 0; i < 22; i++) begin
      ad = (i < 9) ? 12'h100 : 12'h104;
      pulse(i);
      // Random idle gap shows the bit holds after the source is gone
      repeat ($urandom_range(3)) @(posedge clk);
      rchk("event bit", ad, 32'h1 << PB[i]);
      cpu.wr(ad, 32'h1 << PB[i]);
      rchk("cleared bit", ad, 32'h0);
    end
    fork
      cpu.wr(12'h104, 32'h40);
      pulse(19);
    join
    rchk("set over clear", 12'h104, 32'h40);
    cpu.wr(12'h104, 32'h40);
    $display("test event pulses done");
    for (int s = 0; s < 2; s++) begin
      cpu.wr(12'h130, 32'(s * 6));
      @(posedge clk) vl <= s ? 4'h3 : 4'hc;
      rchk("unselected valid", 12'h100, 32'h0);
      @(posedge clk) vl <= 4'hf;
      rchk("valid rise", 12'h100, 32'h5000);
      cpu.wr(12'h100, 32'hffff_ffff);
      @(posedge clk) vl <= s ? 4'h3 : 4'hc;
      @(posedge clk) vl <= 4'h0;
      rchk("valid fall", 12'h100, 32'h2800);
      cpu.wr(12'h100, 32'hffff_ffff);
    end
    $display("test valid select done");
    @(posedge clk) {cpin, pirq} <= 2'b11;
    repeat (5) @(posedge clk);
    rchk("codec irq rise", 12'h100, 32'h40);
    rchk("pbus irq rise", 12'h104, 32'h8);
    cpu.wr(12'h100, 32'h40);
    cpu.wr(12'h104, 32'h8);
    @(posedge clk) {cpin, pirq} <= 2'b00;
    repeat (5) @(posedge clk);
    rchk("codec irq fall", 12'h100, 32'h20);
    rchk("pbus irq fall", 12'h104, 32'h4);
    cpu.wr(12'h100, 32'h20);
    cpu.wr(12'h104, 32'h4);
    $display("test async pins done");
    for (int p = 0; p < 2; p++) begin
      e = 3'($urandom);
      load_rx(p, e);
      rchk("rx load", 12'h104, rx_exp(p, e, 1'b0));
      load_rx(p, 3'h0);
      @(posedge clk) txw <= 2'(1) << p;
      @(posedge clk) txw <= '0;
      rchk("rx and tx overrun", 12'h104, rx_exp(p, e, 1'b1));
      cpu.wr(12'h104, 32'hffff_ffff);
    end
    cpu.wr(12'h130, 32'h8);
    rchk("pbus enable", 12'h104, 32'h0800);
    repeat (2) pulse(17);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) prxl <= 1'b1;
      @(posedge clk) prxl <= 1'b0;
    end
    @(posedge clk) ptxe <= 1'b1;
    @(posedge clk) ptxe <= 1'b0;
    rchk("pbus flags", 12'h104, 32'h0d80);
    cpu.wr(12'h104, 32'hffff_ffff);
    $display("test serial ports done");
    m = $urandom;
    @(posedge clk) mpin <= m;
    repeat (6) @(posedge clk);
    rchk("pin rise", 12'h108, m);
    @(posedge clk) mpin <= '0;
    cpu.wr(12'h108, m & 32'hffff_0000);
    repeat (6) @(posedge clk);
    rchk("pin partial clear", 12'h108, m & 32'h0000_ffff);
    cpu.wr(12'h108, 32'hffff_ffff);
    cpu.wr(12'h1fc, 32'hffff_ffff);
    rchk("unmapped read", 12'h1fc, 32'h0);
    $display("test pins done");
    cpu.wr(12'h120, 32'h0008_0000);
    rchk("enable readback", 12'h120, 32'h0008_0000);
    pulse(0);
    repeat (2) @(posedge clk);
    chk("request no global", 32'h0, 32'(lpr));
    cpu.wr(12'h130, 32'h9);
    repeat (2) @(posedge clk);
    chk("request on", 32'h1, 32'(lpr));
    cpu.wr(12'h100, 32'h0008_0000);
    repeat (2) @(posedge clk);
    chk("request cleared", 32'h0, 32'(lpr));
    $display("test request done");
    give_verdict();
  end
endmodule : ievs_tb_top
